/* File: design/sru_pkg.sv */
// Purpose: shared constants and types for the subroutine return unit
// Assumes: 14-bit instruction words, 8-bit data, 13-bit program counter
// Notes: opcode patterns and cycle counts live here only
package sru_pkg;
  localparam int INSN_W = 14;
  localparam int DATA_W = 8;
  localparam int PC_W = 13;
  localparam int IRQ_CTL_W = 8;
  // global_irq_enable position inside irq_control_reg
  localparam int IRQ_EN_BIT = 7;
  // return from subroutine and interrupt exit, full words
  localparam logic [13:0] RETURN_OP = 14'h0008;
  localparam logic [13:0] IRQ_EXIT_OP = 14'h0009;
  // literal return: top four bits fixed, bits 9:8 don't care
  localparam logic [13:0] LIT_RET_MASK = 14'h3c00;
  localparam logic [13:0] LIT_RET_VAL = 14'h3400;
  localparam int LIT_LSB = 0;
  // every return op takes two instruction cycles
  localparam int RET_CYCLES = 2;
  localparam logic [1:0] IRQ_CTL_RST = 2'h0;

  typedef enum logic [1:0] {
    SRU_RET_NONE = 2'h0,
    SRU_RET_SUB = 2'h1,
    SRU_RET_LIT = 2'h3,
    SRU_RET_IRQ = 2'h2
  } sru_kind_t;

  typedef struct packed {
    logic valid;
    sru_kind_t kind;
    logic [DATA_W-1:0] literal;
  } sru_decode_t;

  typedef enum logic [1:0] {
    SRU_IDLE = 2'h0,
    SRU_FLUSH = 2'h1
  } sru_state_t;
endpackage

/* File: design/sru_decode.sv */
// Purpose: classify an instruction word as one of the return ops
// Assumes: word is stable while insn_valid is high
// Notes: purely combinational
`timescale 1ns/1ps
module sru_decode
  import sru_pkg::*;
(
  // instruction in
  input wire logic [INSN_W-1:0] insn,
  input wire logic insn_valid,
  // decoded result
  output sru_decode_t dec
);
  always_comb begin
    dec = '0;
    dec.literal = insn[LIT_LSB +: DATA_W];
    if (insn_valid && insn == RETURN_OP) begin
      dec.valid = 1'b1;
      dec.kind = SRU_RET_SUB;
    end else if (insn_valid && insn == IRQ_EXIT_OP) begin
      dec.valid = 1'b1;
      dec.kind = SRU_RET_IRQ;
    end else if (insn_valid && (insn & LIT_RET_MASK) == LIT_RET_VAL) begin
      dec.valid = 1'b1;
      dec.kind = SRU_RET_LIT;
    end
  end
endmodule

/* File: design/sru_unit.sv */
// Purpose: execute the three return instructions of an 8-bit core
// Assumes: stack_top holds the return address in the issue cycle, one cycle before stack_pop rises
// Notes: all outputs registered; ce low freezes every flop unless reset is high
//
// What this block does
// RULE1 - the literal return writes its low-byte immediate into acc.
// RULE2 - the literal return pops the stack and loads pc from stack_top.
// RULE3 - the literal return is one word, two cycles, flags untouched.
// RULE4 - the subroutine return pops the stack into pc, flags untouched.
// RULE5 - the subroutine return is one word taking two cycles.
// RULE6 - the interrupt exit pops into pc and sets global_irq_enable.
`timescale 1ns/1ps
module sru_unit
  import sru_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ce,
  // instruction issue
  input wire logic [INSN_W-1:0] insn,
  input wire logic insn_valid,
  // return stack
  input wire logic [PC_W-1:0] stack_top,
  output logic stack_pop,
  // program counter
  output logic pc_load,
  output logic [PC_W-1:0] pc_value,
  // accumulator
  output logic acc_load,
  output logic [DATA_W-1:0] acc_value,
  // interrupt control
  output logic global_irq_enable_set,
  // sequencing
  output logic busy,
  output logic done
);
  sru_decode_t dec;
  sru_state_t state, next_state;
  logic next_stack_pop, next_pc_load, next_acc_load, next_irq_en_set;
  logic next_busy, next_done;
  logic [PC_W-1:0] next_pc_value;
  logic [DATA_W-1:0] next_acc_value;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  sru_decode u_dec (
    .insn(insn),
    .insn_valid(insn_valid && state == SRU_IDLE),
    .dec(dec)
  );

  // ----------------------------------------
  // sequencing
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_stack_pop = 1'b0;
    next_pc_load = 1'b0;
    next_pc_value = pc_value;
    next_acc_load = 1'b0;
    next_acc_value = acc_value;
    next_irq_en_set = 1'b0;
    next_busy = 1'b0;
    next_done = 1'b0;
    case (state)
      SRU_IDLE: begin
        if (dec.valid) begin
          // RULE2 RULE4 RULE6 pop into pc
          next_stack_pop = 1'b1;
          next_pc_load = 1'b1;
          next_pc_value = stack_top;
          // RULE1 literal to acc
          if (dec.kind == SRU_RET_LIT) begin
            next_acc_load = 1'b1;
            next_acc_value = dec.literal;
          end
          // RULE6 enable interrupts
          if (dec.kind == SRU_RET_IRQ) begin
            next_irq_en_set = 1'b1;
          end
          // RULE3 RULE5 second cycle flush
          next_busy = 1'b1;
          next_state = SRU_FLUSH;
        end
      end
      SRU_FLUSH: begin
        next_done = 1'b1;
        next_state = SRU_IDLE;
      end
      default: next_state = SRU_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state <= SRU_IDLE;
      stack_pop <= 1'b0;
      pc_load <= 1'b0;
      pc_value <= '0;
      acc_load <= 1'b0;
      acc_value <= '0;
      global_irq_enable_set <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      stack_pop <= next_stack_pop;
      pc_load <= next_pc_load;
      pc_value <= next_pc_value;
      acc_load <= next_acc_load;
      acc_value <= next_acc_value;
      global_irq_enable_set <= next_irq_en_set;
      busy <= next_busy;
      done <= next_done;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_lit_acc_value: assert property ( // RULE1
    @(posedge core_clk) disable iff (reset)
    (ce && state == SRU_IDLE && insn_valid
      && (insn & LIT_RET_MASK) == LIT_RET_VAL)
    |=> (acc_load && acc_value == $past(insn[LIT_LSB +: DATA_W])))
    else $error("literal not placed in acc");

  a_lit_pc_pop: assert property ( // RULE2
    @(posedge core_clk) disable iff (reset)
    (ce && dec.valid && dec.kind == SRU_RET_LIT)
    |=> (stack_pop && pc_load && pc_value == $past(stack_top)))
    else $error("literal return did not pop into pc");

  a_lit_two_cyc: assert property ( // RULE3
    @(posedge core_clk) disable iff (reset)
    (ce && dec.valid && dec.kind == SRU_RET_LIT) ##1 ce
    |=> done)
    else $error("literal return not two cycles");

  a_sub_pc_pop: assert property ( // RULE4
    @(posedge core_clk) disable iff (reset)
    (ce && state == SRU_IDLE && insn_valid && insn == RETURN_OP)
    |=> (pc_load && stack_pop && !acc_load
      && !global_irq_enable_set && pc_value == $past(stack_top)))
    else $error("return did not pop into pc");

  a_sub_two_cyc: assert property ( // RULE5
    @(posedge core_clk) disable iff (reset)
    (ce && dec.valid && dec.kind == SRU_RET_SUB) ##1 ce
    |=> (done && !pc_load))
    else $error("return not two cycles");

  a_irq_en_set: assert property ( // RULE6
    @(posedge core_clk) disable iff (reset)
    (ce && state == SRU_IDLE && insn_valid && insn == IRQ_EXIT_OP)
    |=> (global_irq_enable_set && pc_load && !acc_load))
    else $error("interrupt exit did not set enable");

  a_pop_once: assert property ( // RULE2
    @(posedge core_clk) disable iff (reset)
    (stack_pop && ce) |=> !stack_pop)
    else $error("stack popped twice");

  a_irq_en_only: assert property ( // RULE6
    @(posedge core_clk) disable iff (reset)
    global_irq_enable_set |-> (pc_load && busy))
    else $error("enable set outside interrupt exit");

  a_irq_pc_pop: assert property ( // RULE6
    @(posedge core_clk) disable iff (reset)
    (ce && dec.valid && dec.kind == SRU_RET_IRQ)
    |=> (stack_pop && pc_value == $past(stack_top)))
    else $error("interrupt exit did not pop into pc");

  a_irq_two_cyc: assert property ( // RULE6
    @(posedge core_clk) disable iff (reset)
    (ce && dec.valid && dec.kind == SRU_RET_IRQ) ##1 ce
    |=> (done && !global_irq_enable_set))
    else $error("interrupt exit not two cycles");

  a_sub_no_acc: assert property ( // RULE4
    @(posedge core_clk) disable iff (reset)
    (ce && dec.valid && dec.kind == SRU_RET_SUB)
    |=> (!acc_load && $stable(acc_value)))
    else $error("return touched acc");

  a_lit_only_acc: assert property ( // RULE1
    @(posedge core_clk) disable iff (reset)
    acc_load |-> (pc_load && stack_pop && busy
      && !global_irq_enable_set))
    else $error("acc loaded outside literal return");

  a_pop_with_pc: assert property ( // RULE2 RULE4
    @(posedge core_clk) disable iff (reset)
    stack_pop |-> pc_load)
    else $error("pop without pc load");

  a_acc_hold: assert property ( // RULE1
    @(posedge core_clk) disable iff (reset)
    (!$stable(acc_value) && !$past(reset)) |-> acc_load)
    else $error("acc value moved without load");

  a_pc_hold: assert property ( // RULE4
    @(posedge core_clk) disable iff (reset)
    (!$stable(pc_value) && !$past(reset)) |-> pc_load)
    else $error("pc value moved without load");

  a_flush_refuse: assert property ( // RULE5
    @(posedge core_clk) disable iff (reset)
    (ce && state == SRU_FLUSH)
    |=> (!stack_pop && !pc_load && !acc_load
      && !global_irq_enable_set && !busy && done))
    else $error("flush cycle not quiet");

  a_busy_to_done: assert property ( // RULE3
    @(posedge core_clk) disable iff (reset)
    (ce && busy) |=> (done && !busy))
    else $error("busy not followed by done");

  a_done_after_busy: assert property ( // RULE5
    @(posedge core_clk) disable iff (reset)
    $rose(done) |-> $past(busy))
    else $error("done without busy");

  a_ce_freeze: assert property ( // RULE3 RULE5
    @(posedge core_clk) disable iff (reset)
    !ce |=> ($stable(stack_pop) && $stable(pc_load)
      && $stable(pc_value) && $stable(acc_load) && $stable(acc_value)
      && $stable(global_irq_enable_set) && $stable(busy)
      && $stable(done)))
    else $error("outputs moved while ce low");
endmodule

/* File: verif/tb_subroutine_return_unit.sv */
// Purpose: self-checking bench for the return unit
// Assumes: outputs are settled 1 ns after the rising edge
// Notes: inputs move 1 ns after each rising edge
`timescale 1ns/1ps
module tb_subroutine_return_unit;
  import sru_pkg::*;
  logic core_clk, reset, ce, insn_valid;
  logic [INSN_W-1:0] insn;
  logic [PC_W-1:0] stack_top, pc_value;
  logic [DATA_W-1:0] acc_value;
  logic stack_pop, pc_load, acc_load, global_irq_enable_set, busy, done;
  int n_fail = 0;
  int compares = 0;
  int cycles = 0;
  sru_unit uut (.core_clk(core_clk), .reset(reset), .ce(ce),
    .insn(insn), .insn_valid(insn_valid), .stack_top(stack_top),
    .stack_pop(stack_pop), .pc_load(pc_load), .pc_value(pc_value),
    .acc_load(acc_load), .acc_value(acc_value),
    .global_irq_enable_set(global_irq_enable_set), .busy(busy),
    .done(done));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_fail++;
      test_done();
    end
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic test_done();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    compares++;
    if (e !== g) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic step();
    @(posedge core_clk);
    #1;
  endtask
  function automatic logic [15:0] strb();
    strb = {10'h000, stack_pop, pc_load, acc_load,
            global_irq_enable_set, busy, done};
  endfunction
  task automatic quiet(input string nm);
    chk(nm, 16'h0000, strb());
  endtask
  // issue one return, offer nxt in the flush cycle
  task automatic run(input logic [13:0] op, input logic [12:0] top,
                     input logic lit, input logic irq,
                     input logic [13:0] nxt);
    insn = op;
    insn_valid = 1'b1;
    stack_top = top;
    step();
    insn = nxt;
    stack_top = ~top;
    chk("strobes", {10'h000, 2'b11, lit, irq, 2'b10}, strb());
    chk("pc_value", {3'h0, top}, {3'h0, pc_value});
    if (lit) chk("acc_value", {8'h00, op[7:0]}, {8'h00, acc_value});
    step();
    chk("flush", 16'h0001, strb());
    chk("pc_hold", {3'h0, top}, {3'h0, pc_value});
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_literal();
    run(14'h3455, 13'h1abc, 1'b1, 1'b0, RETURN_OP);
    run(14'h37aa, 13'h0123, 1'b1, 1'b0, 14'h3400);
    insn_valid = 1'b0;
    step();
    $display("literal return finished");
  endtask
  task automatic t_subret();
    run(RETURN_OP, 13'h1fff, 1'b0, 1'b0, IRQ_EXIT_OP);
    insn_valid = 1'b0;
    step();
    $display("subroutine return finished");
  endtask
  task automatic t_irq();
    run(IRQ_EXIT_OP, 13'h0000, 1'b0, 1'b1, 14'h3455);
    insn_valid = 1'b0;
    step();
    $display("interrupt exit finished");
  endtask
  task automatic t_other();
    insn = 14'h0007;
    insn_valid = 1'b1;
    step();
    step();
    quiet("op_0007");
    insn = 14'h3800;
    step();
    step();
    quiet("op_3800");
    ce = 1'b0;
    insn = RETURN_OP;
    stack_top = 13'h0abc;
    step();
    step();
    quiet("ce_low");
    ce = 1'b1;
    step();
    ce = 1'b0;
    insn_valid = 1'b0;
    chk("ce_take", 16'h0032, strb());
    step();
    chk("ce_hold", 16'h0032, strb());
    ce = 1'b1;
    step();
    chk("ce_flush", 16'h0001, strb());
    chk("ce_pc", 16'h0abc, {3'h0, pc_value});
    $display("ignored ops finished");
  endtask
  initial begin
    reset = 1'b1;
    ce = 1'b1;
    insn = 14'h0000;
    insn_valid = 1'b0;
    stack_top = 13'h0000;
    repeat (6) @(posedge core_clk);
    #1;
    reset = 1'b0;
    quiet("after_reset");
    t_literal();
    t_subret();
    t_irq();
    t_other();
    test_done();
  end
endmodule
